// ### design/iop_pkg.sv
/*
 Package for the port drive mode controller: register map, field layout, drive codes, pad control struct.
 Assumes one 8-pin port, two USB-capable pins at bits 7 and 6, and a simple strobe register port.
*/
package iop_pkg;
    localparam int          IOP_PINS          = 8;
    localparam int          IOP_ADDR_W        = 8;
    localparam int          IOP_DATA_W        = 8;
    localparam int          IOP_AUX_W         = 16;
    // Port form registers
    localparam logic [7:0]  ADDR_OUT_VALUE    = 8'h00;
    localparam logic [7:0]  ADDR_PIN_STATE    = 8'h01;
    localparam logic [7:0]  ADDR_DRIVE0       = 8'h02;
    localparam logic [7:0]  ADDR_DRIVE1       = 8'h03;
    localparam logic [7:0]  ADDR_DRIVE2       = 8'h04;
    localparam logic [7:0]  ADDR_BYPASS       = 8'h05;
    localparam logic [7:0]  ADDR_REGULATED    = 8'h06;
    localparam logic [7:0]  ADDR_INT_RISE     = 8'h07;
    localparam logic [7:0]  ADDR_INT_FALL     = 8'h08;
    localparam logic [7:0]  ADDR_INT_STATUS   = 8'h09;
    localparam logic [7:0]  ADDR_BIDIR_EN     = 8'h0A;
    localparam logic [7:0]  ADDR_USB_DRIVE_EN = 8'h0B;
    localparam logic [7:0]  ADDR_USB_PULL_EN  = 8'h0C;
    localparam logic [7:0]  ADDR_USB_MODE     = 8'h0D;
    localparam logic [7:0]  ADDR_RESET_DRIVE  = 8'h0E;
    localparam logic [7:0]  ADDR_PIN_BASE     = 8'h10;
    localparam logic [7:0]  ADDR_PIN_LAST     = 8'h17;
    // Per-pin register fields
    localparam int          PF_OUT            = 0;
    localparam int          PF_STATE          = 1;
    localparam int          PF_DM_LO          = 2;
    localparam int          PF_DM_HI          = 4;
    localparam int          PF_BYPASS         = 5;
    localparam int          PF_RISE           = 6;
    localparam int          PF_FALL           = 7;
    // Drive select codes
    localparam logic [2:0]  DM_ANALOG_Z       = 3'h0;
    localparam logic [2:0]  DM_DIGITAL_Z      = 3'h1;
    localparam logic [2:0]  DM_RES_UP         = 3'h2;
    localparam logic [2:0]  DM_RES_DOWN       = 3'h3;
    localparam logic [2:0]  DM_OD_LOW         = 3'h4;
    localparam logic [2:0]  DM_OD_HIGH        = 3'h5;
    localparam logic [2:0]  DM_STRONG         = 3'h6;
    localparam logic [2:0]  DM_RES_BOTH       = 3'h7;
    localparam logic [7:0]  RESET_DRIVE_DEF   = 8'h00;
    localparam logic [7:0]  USB_PIN_MASK      = 8'hC0;
    localparam int          PULL_OHMS         = 5000;

    typedef struct packed {
        logic strong_hi;
        logic strong_lo;
        logic res_hi;
        logic res_lo;
        logic in_en;
    } iop_pad_s;
endpackage

// ### design/iop_port.sv
/*
 One I/O port: drive mode decode, USB pin drive, port and pin register forms, edge interrupts.
 Assumes pins and routed signals are synchronous to clk and the pad cell acts on the pad struct.
*/
`timescale 1ns/10ps
// How it works
// - Three-bit drive select gives eight modes
// - Drive follows output value or bypass signal
// - Code 4: low strong, high floats
// - Code 5: high strong, low floats
// - Code 7: resistive pull both ways
// - No resistive pulls in regulated output
// - USB pins use drive and pull enables
// - USB pins: zero strong low, one per enables
// - USB mode ignores USB pin enables
// - Port drive writes skip USB pin bits
// - Per-pin rising, falling or both edge interrupt
// - One interrupt line for the port
// - Pin state read apart from output value
// - Port and pin forms share storage
// - Reset drive pattern writable, but reset reloads RESET_DRIVE_DEF before it is applied
// - CPU and DMA read and write pins
// - Event sets status bit, requests interrupt
// - Auxiliary enable switches digital Z and drive
// - Pin register holds the eight field bits of one pin
module iop_port
    import iop_pkg::*;
(
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    input  wire logic [iop_pkg::IOP_ADDR_W-1:0]  addr,
    input  wire logic [iop_pkg::IOP_DATA_W-1:0]  wdata,
    input  wire logic                            wr_stb,
    input  wire logic                            rd_stb,
    output logic      [iop_pkg::IOP_DATA_W-1:0]  rdata,
    input  wire logic [iop_pkg::IOP_PINS-1:0]    pin_in,
    input  wire logic [iop_pkg::IOP_PINS-1:0]    bypass_in,
    input  wire logic [iop_pkg::IOP_AUX_W-1:0]   aux_oe,
    input  wire logic [31:0]                     aux_sel,
    output iop_pkg::iop_pad_s [iop_pkg::IOP_PINS-1:0] pad_ctrl,
    output logic      [iop_pkg::IOP_PINS-1:0]    pin_sync,
    output logic                                 port_irq
);
    import iop_pkg::*;

    logic [7:0] out_ff, dm0_ff, dm1_ff, dm2_ff, byp_ff, reg_ff, rise_ff, fall_ff;
    logic [7:0] stat_ff, bidir_ff, usb_drv_ff, usb_pull_ff, rst_drv_ff;
    logic       usb_mode_ff;
    logic       init_ff;
    logic [7:0] sync1_ff, sync2_ff, prev_ff;
    logic [7:0] rdata_ff;
    logic [7:0] edge_evt;
    logic       pin_wr;
    logic [2:0] pin_idx;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] merge_port(input logic [7:0] old, input logic [7:0] nv);
        merge_port = (old & USB_PIN_MASK) | (nv & ~USB_PIN_MASK);
    endfunction

    assign pin_wr  = wr_stb && (addr >= ADDR_PIN_BASE) && (addr <= ADDR_PIN_LAST);
    assign pin_idx = addr[2:0];

    // ----------------------------------------
    // Configuration storage
    // ----------------------------------------
    // Reset drive pattern is applied once after reset release, since an async reset may only load constants
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_drv_ff <= RESET_DRIVE_DEF;
        end else if (wr_stb && addr == ADDR_RESET_DRIVE) begin
            rst_drv_ff <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_ff <= 1'b1;
        end else begin
            init_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ff  <= 8'h00;
            dm0_ff  <= 8'h00;
            dm1_ff  <= 8'h00;
            dm2_ff  <= 8'h00;
            byp_ff  <= 8'h00;
            rise_ff <= 8'h00;
            fall_ff <= 8'h00;
        end else if (init_ff) begin
            // Pattern bit set selects digital Z, clear leaves analog Z
            dm0_ff <= rst_drv_ff & ~USB_PIN_MASK;
        end else if (wr_stb) begin
            if (addr == ADDR_OUT_VALUE) begin
                out_ff <= wdata;
            end else if (addr == ADDR_DRIVE0) begin
                dm0_ff <= merge_port(dm0_ff, wdata);
            end else if (addr == ADDR_DRIVE1) begin
                dm1_ff <= merge_port(dm1_ff, wdata);
            end else if (addr == ADDR_DRIVE2) begin
                dm2_ff <= merge_port(dm2_ff, wdata);
            end else if (addr == ADDR_BYPASS) begin
                byp_ff <= wdata;
            end else if (addr == ADDR_INT_RISE) begin
                rise_ff <= wdata;
            end else if (addr == ADDR_INT_FALL) begin
                fall_ff <= wdata;
            end else if (pin_wr) begin
                out_ff[pin_idx]  <= wdata[PF_OUT];
                byp_ff[pin_idx]  <= wdata[PF_BYPASS];
                rise_ff[pin_idx] <= wdata[PF_RISE];
                fall_ff[pin_idx] <= wdata[PF_FALL];
                if (!USB_PIN_MASK[pin_idx]) begin
                    dm0_ff[pin_idx] <= wdata[PF_DM_LO];
                    dm1_ff[pin_idx] <= wdata[PF_DM_LO+1];
                    dm2_ff[pin_idx] <= wdata[PF_DM_HI];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_ff      <= 8'h00;
            bidir_ff    <= 8'h00;
            usb_drv_ff  <= 8'h00;
            usb_pull_ff <= 8'h00;
            usb_mode_ff <= 1'b0;
        end else if (wr_stb) begin
            if (addr == ADDR_REGULATED) begin
                reg_ff <= wdata & ~USB_PIN_MASK;
            end else if (addr == ADDR_BIDIR_EN) begin
                bidir_ff <= wdata;
            end else if (addr == ADDR_USB_DRIVE_EN) begin
                usb_drv_ff <= wdata & USB_PIN_MASK;
            end else if (addr == ADDR_USB_PULL_EN) begin
                usb_pull_ff <= wdata & USB_PIN_MASK;
            end else if (addr == ADDR_USB_MODE) begin
                usb_mode_ff <= wdata[0];
            end
        end
    end

    // ----------------------------------------
    // Input sync and edge interrupts
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            prev_ff  <= 8'h00;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign edge_evt = (rise_ff & sync2_ff & ~prev_ff) | (fall_ff & ~sync2_ff & prev_ff);

    // Status clears on read; a new event in the read cycle stays set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff <= 8'h00;
        end else if (rd_stb && addr == ADDR_INT_STATUS) begin
            stat_ff <= edge_evt;
        end else begin
            stat_ff <= stat_ff | edge_evt;
        end
    end

    assign port_irq = |stat_ff;
    assign pin_sync = sync2_ff;

    // ----------------------------------------
    // Drive decode
    // ----------------------------------------
    always_comb begin
        logic [2:0] dm;
        logic       v;
        logic       oe;
        dm = 3'h0;
        v  = 1'b0;
        oe = 1'b0;
        for (int i = 0; i < IOP_PINS; i++) begin
            v  = byp_ff[i] ? bypass_in[i] : out_ff[i];
            dm = {dm2_ff[i], dm1_ff[i], dm0_ff[i]};
            oe = aux_oe[aux_sel[i*4 +: 4]];
            if (bidir_ff[i] && !oe) begin
                dm = DM_DIGITAL_Z;
            end
            if (reg_ff[i] && (dm == DM_RES_UP || dm == DM_RES_DOWN || dm == DM_RES_BOTH)) begin
                dm = DM_STRONG;
            end
            pad_ctrl[i] = '0;
            pad_ctrl[i].in_en = (dm != DM_ANALOG_Z);
            if (USB_PIN_MASK[i]) begin
                pad_ctrl[i].in_en = 1'b1;
                if (usb_mode_ff) begin
                    pad_ctrl[i] = '0;
                end else if (!v) begin
                    pad_ctrl[i].strong_lo = 1'b1;
                end else if (usb_drv_ff[i]) begin
                    pad_ctrl[i].strong_hi = 1'b1;
                end else begin
                    pad_ctrl[i].res_hi = usb_pull_ff[i];
                end
            end else begin
                case (dm)
                    DM_RES_UP: begin
                        pad_ctrl[i].res_hi    = v;
                        pad_ctrl[i].strong_lo = !v;
                    end
                    DM_RES_DOWN: begin
                        pad_ctrl[i].strong_hi = v;
                        pad_ctrl[i].res_lo    = !v;
                    end
                    DM_OD_LOW: begin
                        pad_ctrl[i].strong_lo = !v;
                    end
                    DM_OD_HIGH: begin
                        pad_ctrl[i].strong_hi = v;
                    end
                    DM_STRONG: begin
                        pad_ctrl[i].strong_hi = v;
                        pad_ctrl[i].strong_lo = !v;
                    end
                    DM_RES_BOTH: begin
                        pad_ctrl[i].res_hi = v;
                        pad_ctrl[i].res_lo = !v;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (rd_stb) begin
            if (addr == ADDR_OUT_VALUE) begin
                rdata_ff <= out_ff;
            end else if (addr == ADDR_PIN_STATE) begin
                rdata_ff <= sync2_ff;
            end else if (addr == ADDR_DRIVE0) begin
                rdata_ff <= dm0_ff;
            end else if (addr == ADDR_DRIVE1) begin
                rdata_ff <= dm1_ff;
            end else if (addr == ADDR_DRIVE2) begin
                rdata_ff <= dm2_ff;
            end else if (addr == ADDR_BYPASS) begin
                rdata_ff <= byp_ff;
            end else if (addr == ADDR_REGULATED) begin
                rdata_ff <= reg_ff;
            end else if (addr == ADDR_INT_RISE) begin
                rdata_ff <= rise_ff;
            end else if (addr == ADDR_INT_FALL) begin
                rdata_ff <= fall_ff;
            end else if (addr == ADDR_INT_STATUS) begin
                rdata_ff <= stat_ff;
            end else if (addr == ADDR_BIDIR_EN) begin
                rdata_ff <= bidir_ff;
            end else if (addr == ADDR_USB_DRIVE_EN) begin
                rdata_ff <= usb_drv_ff;
            end else if (addr == ADDR_USB_PULL_EN) begin
                rdata_ff <= usb_pull_ff;
            end else if (addr == ADDR_USB_MODE) begin
                rdata_ff <= {7'h00, usb_mode_ff};
            end else if (addr == ADDR_RESET_DRIVE) begin
                rdata_ff <= rst_drv_ff;
            end else if (addr >= ADDR_PIN_BASE && addr <= ADDR_PIN_LAST) begin
                rdata_ff <= {fall_ff[pin_idx], rise_ff[pin_idx], byp_ff[pin_idx], dm2_ff[pin_idx],
                             dm1_ff[pin_idx], dm0_ff[pin_idx], sync2_ff[pin_idx], out_ff[pin_idx]};
            end else begin
                rdata_ff <= 8'h00;
            end
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign rdata = rdata_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Held off until two edges after release, since the flops hold zero while the pins still move
    a_sync_two_flops: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n, 2) |-> (sync2_ff == $past(pin_in, 2))) else $error("pin sync latency wrong");
    a_rise_sets_status: assert property (@(posedge clk) disable iff (!rst_n)
        (rise_ff[0] && $rose(sync2_ff[0])) |=> stat_ff[0]) else $error("rising edge lost");
    a_irq_follows_status: assert property (@(posedge clk) disable iff (!rst_n)
        (|edge_evt) |=> port_irq) else $error("no port interrupt");
    a_irq_one_line: assert property (@(posedge clk) disable iff (!rst_n)
        port_irq == (stat_ff != 8'h00)) else $error("irq not status or");
    a_od_low_float: assert property (@(posedge clk) disable iff (!rst_n)
        ({dm2_ff[0], dm1_ff[0], dm0_ff[0]} == DM_OD_LOW && !bidir_ff[0] && out_ff[0] && !byp_ff[0])
        |-> (pad_ctrl[0].strong_lo == 1'b0 && pad_ctrl[0].strong_hi == 1'b0)) else $error("open drain low");
    a_od_high_drive: assert property (@(posedge clk) disable iff (!rst_n)
        ({dm2_ff[0], dm1_ff[0], dm0_ff[0]} == DM_OD_HIGH && !bidir_ff[0] && !byp_ff[0])
        |-> (pad_ctrl[0].strong_hi == out_ff[0] && !pad_ctrl[0].strong_lo)) else $error("open drain high");
    a_usb_zero_low: assert property (@(posedge clk) disable iff (!rst_n)
        (!usb_mode_ff && !out_ff[7] && !byp_ff[7]) |-> pad_ctrl[7].strong_lo) else $error("usb low");
    a_usb_mode_off: assert property (@(posedge clk) disable iff (!rst_n)
        usb_mode_ff |-> (pad_ctrl[6] == '0 && pad_ctrl[7] == '0)) else $error("usb mode drive");
    a_regulated_no_pull: assert property (@(posedge clk) disable iff (!rst_n)
        reg_ff[3] |-> (!pad_ctrl[3].res_hi && !pad_ctrl[3].res_lo)) else $error("pull in regulated");
    a_usb_bits_kept: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_stb && addr == ADDR_DRIVE0 && !init_ff) |=> (dm0_ff[7:6] == $past(dm0_ff[7:6])))
        else $error("usb drive bits changed");
    a_read_next_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_stb && addr == ADDR_PIN_STATE) |=> (rdata == $past(sync2_ff))) else $error("pin state read");
    a_strong_both: assert property (@(posedge clk) disable iff (!rst_n)
        ({dm2_ff[0], dm1_ff[0], dm0_ff[0]} == DM_STRONG && !bidir_ff[0] && !byp_ff[0])
        |-> (pad_ctrl[0].strong_hi == out_ff[0] && pad_ctrl[0].strong_lo == !out_ff[0])) else $error("strong drive");
    a_res_both_pull: assert property (@(posedge clk) disable iff (!rst_n)
        ({dm2_ff[0], dm1_ff[0], dm0_ff[0]} == DM_RES_BOTH && !bidir_ff[0] && !byp_ff[0] && !reg_ff[0])
        |-> (pad_ctrl[0].res_hi == out_ff[0] && pad_ctrl[0].res_lo == !out_ff[0])) else $error("pull both ways");
    a_usb_drive_high: assert property (@(posedge clk) disable iff (!rst_n)
        (!usb_mode_ff && out_ff[7] && !byp_ff[7] && usb_drv_ff[7]) |-> pad_ctrl[7].strong_hi) else $error("usb high");
    a_usb_pull_high: assert property (@(posedge clk) disable iff (!rst_n)
        (!usb_mode_ff && out_ff[7] && !byp_ff[7] && !usb_drv_ff[7])
        |-> (pad_ctrl[7].res_hi == usb_pull_ff[7] && !pad_ctrl[7].strong_hi)) else $error("usb pull");
    a_bidir_digital_z: assert property (@(posedge clk) disable iff (!rst_n)
        (bidir_ff[3] && !aux_oe[aux_sel[15:12]]) |-> (pad_ctrl[3] == 5'h01)) else $error("bidir not digital z");
    a_status_clear_read: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_stb && addr == ADDR_INT_STATUS && edge_evt == 8'h00) |=> (stat_ff == 8'h00)) else $error("status kept");
    a_rdata_idle_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !rd_stb |=> (rdata == 8'h00)) else $error("read data not idle");
    a_pin_form_dm: assert property (@(posedge clk) disable iff (!rst_n)
        (pin_wr && !init_ff && pin_idx == 3'h3)
        |=> ({dm2_ff[3], dm1_ff[3], dm0_ff[3]} == $past(wdata[PF_DM_HI:PF_DM_LO]))) else $error("pin form drive");
    a_reset_pattern: assert property (@(posedge clk) disable iff (!rst_n)
        init_ff |=> (dm0_ff == ($past(rst_drv_ff) & ~USB_PIN_MASK))) else $error("reset pattern");
endmodule

// ### test/iop_board.sv
/*
 Board model for one 8-pin port: turns pad controls and optional board drivers into pin levels.
 Assumes the bench changes ext_en and ext_val just after a rising edge of clk.
*/
`timescale 1ns/10ps
// ----------------------------------------
// Pin level resolution
// ----------------------------------------
module iop_board
    import iop_pkg::*;
(
    input  wire logic                              clk,
    input  wire iop_pkg::iop_pad_s [7:0]           pad_ctrl,
    input  wire logic [7:0]                        ext_en,
    input  wire logic [7:0]                        ext_val,
    output logic      [7:0]                        pin_lvl
);
    logic [7:0] flt_ff = 8'h00;

    // A floating pin flips every cycle, so a stale level never passes
    always @(posedge clk) begin
        flt_ff <= ~pin_lvl;
    end

    // Strong drive beats the board drivers, which beat the 5k pulls
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_ctrl[i].strong_hi) pin_lvl[i] = 1'b1;
            else if (pad_ctrl[i].strong_lo) pin_lvl[i] = 1'b0;
            else if (ext_en[i]) pin_lvl[i] = ext_val[i];
            else if (pad_ctrl[i].res_hi) pin_lvl[i] = 1'b1;
            else if (pad_ctrl[i].res_lo) pin_lvl[i] = 1'b0;
            else pin_lvl[i] = flt_ff[i];
        end
    end
endmodule

// ### test/testbench.sv
/*
 Self-checking bench for the port drive controller: drive table, USB pins, registers, edge events.
 Assumes the board model iop_board resolves pin levels from the pad controls.
*/
`timescale 1ns/10ps
module testbench;
    import iop_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic                    clk       = 1'b0;
    logic                    rst_n     = 1'b0;
    logic [7:0]              addr      = 8'h00;
    logic [7:0]              wdata     = 8'h00;
    logic                    wr_stb    = 1'b0;
    logic                    rd_stb    = 1'b0;
    logic [7:0]              bypass_in = 8'h00;
    logic [15:0]             aux_oe    = 16'h0000;
    logic [31:0]             aux_sel   = 32'h0000_9000;
    logic [7:0]              ext_en    = 8'h00;
    logic [7:0]              ext_val   = 8'h00;
    logic [7:0]              rdata;
    logic [7:0]              pin_lvl;
    logic [7:0]              pin_sync;
    logic                    port_irq;
    iop_pad_s [7:0]          pad_ctrl;
    int                      bad_count = 0;
    int                      checked   = 0;
    // Rows: drive code, drive nibble for value 1, for value 0
    logic [10:0] rows [8] = '{{3'h0, 4'h0, 4'h0}, {3'h1, 4'h0, 4'h0}, {3'h2, 4'h2, 4'h4},
        {3'h3, 4'h8, 4'h1}, {3'h4, 4'h0, 4'h4}, {3'h5, 4'h8, 4'h0}, {3'h6, 4'h8, 4'h4}, {3'h7, 4'h2, 4'h1}};

    always #50 clk = ~clk;

    iop_port dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .pin_in(pin_lvl), .bypass_in(bypass_in), .aux_oe(aux_oe), .aux_sel(aux_sel),
        .pad_ctrl(pad_ctrl), .pin_sync(pin_sync), .port_irq(port_irq));
    iop_board board (.clk(clk), .pad_ctrl(pad_ctrl), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cpad(input int p, input logic [3:0] e);
        #1;
        chk("pad drive", {4'h0, e}, {4'h0, pad_ctrl[p][4:1]});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk("read data", e, rdata);
    endtask
    task automatic test_done;
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 200 cycles the sequence needs
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        test_done;
    end

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("reset pad", 8'h00, {3'h0, pad_ctrl[0]});
        rd(ADDR_RESET_DRIVE, RESET_DRIVE_DEF);
        wr(ADDR_RESET_DRIVE, 8'h3C);
        rd(ADDR_RESET_DRIVE, 8'h3C);
        rd(ADDR_INT_STATUS, 8'h00);
        wr(ADDR_OUT_VALUE, 8'h55);
        for (int r = 0; r < 8; r++) begin
            wr(ADDR_DRIVE0, {8{rows[r][8]}});
            wr(ADDR_DRIVE1, {8{rows[r][9]}});
            wr(ADDR_DRIVE2, {8{rows[r][10]}});
            for (int p = 0; p < 6; p++) begin
                cpad(p, p[0] ? rows[r][3:0] : rows[r][7:4]);
            end
            if (r < 2) chk("input enable", {7'h0, r == 1}, {7'h0, pad_ctrl[0].in_en});
        end
        rd(ADDR_DRIVE0, 8'h3F);
        rd(ADDR_DRIVE2, 8'h3F);
        // USB pins: pull enable, drive enable, output value
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_USB_PULL_EN, {8{k[2]}} & USB_PIN_MASK);
            wr(ADDR_USB_DRIVE_EN, {8{k[1]}} & USB_PIN_MASK);
            wr(ADDR_OUT_VALUE, {8{k[0]}});
            cpad(7, !k[0] ? 4'h4 : k[1] ? 4'h8 : k[2] ? 4'h2 : 4'h0);
            cpad(6, !k[0] ? 4'h4 : k[1] ? 4'h8 : k[2] ? 4'h2 : 4'h0);
        end
        wr(ADDR_USB_MODE, 8'h01);
        #1;
        chk("usb mode pad", 8'h00, {3'h0, pad_ctrl[7]});
        wr(ADDR_USB_MODE, 8'h00);
        wr(ADDR_USB_PULL_EN, 8'h00);
        wr(ADDR_USB_DRIVE_EN, 8'h00);
        // All pins digital Z, the board drives them
        wr(ADDR_DRIVE0, 8'hFF);
        wr(ADDR_DRIVE1, 8'h00);
        wr(ADDR_DRIVE2, 8'h00);
        wr(ADDR_OUT_VALUE, 8'hC0);
        @(posedge clk);
        ext_en <= 8'hFF;
        ext_val <= 8'hA5;
        repeat (4) @(posedge clk);
        rd(ADDR_PIN_STATE, 8'hA5);
        chk("pin sync", 8'hA5, pin_sync);
        rd(ADDR_OUT_VALUE, 8'hC0);
        @(posedge clk);
        ext_val <= 8'h00;
        repeat (4) @(posedge clk);
        rd(ADDR_INT_STATUS, 8'h00);
        wr(ADDR_INT_RISE, 8'h05);
        wr(ADDR_INT_FALL, 8'h06);
        @(posedge clk);
        ext_val <= 8'h07;
        repeat (4) @(posedge clk);
        #1;
        chk("irq", 8'h01, {7'h0, port_irq});
        rd(ADDR_INT_STATUS, 8'h05);
        chk("irq", 8'h00, {7'h0, port_irq});
        @(posedge clk);
        ext_val <= 8'h00;
        repeat (4) @(posedge clk);
        rd(ADDR_INT_STATUS, 8'h06);
        // Pin form on pin 3: value 1, strong drive
        wr(8'h13, 8'h19);
        cpad(3, 4'h8);
        rd(ADDR_DRIVE1, 8'h08);
        repeat (3) @(posedge clk);
        rd(8'h13, 8'h1B);
        wr(ADDR_BYPASS, 8'h08);
        cpad(3, 4'h4);
        @(posedge clk);
        bypass_in <= 8'h08;
        cpad(3, 4'h8);
        // Regulated output turns the pull-up code into strong drive
        wr(ADDR_REGULATED, 8'h08);
        wr(8'h13, 8'h09);
        cpad(3, 4'h8);
        wr(ADDR_BIDIR_EN, 8'h08);
        cpad(3, 4'h0);
        chk("bidir input", 8'h01, {7'h0, pad_ctrl[3].in_en});
        @(posedge clk);
        aux_oe <= 16'h0200;
        cpad(3, 4'h8);
        rd(8'hFF, 8'h00);
        test_done;
    end
endmodule
